/* File: dv/tcc_io_model.sv */
// Far side: capture lines and external clocks
`timescale 1ns/1ns
module tcc_io_model #(
  parameter int SLOW_DIV = 50 // Slow clock half period in mclk
) (
  input wire logic mclk, // Clock
  output logic slow_osc_clk, // Slow clock level
  output logic [2:0] ext_clock, // External clocks
  output logic [2:0] io_line_a, // Line A per channel
  output logic [2:0] io_line_b // Line B per channel
);
  int cnt = 0;
  initial
  begin
    slow_osc_clk = 1'b0;
    ext_clock = '0;
    io_line_a = '0;
    io_line_b = '0;
  end
  // Free-running slow clock
  always @(posedge mclk)
  begin
    cnt <= (cnt == SLOW_DIV - 1) ? 0 : cnt + 1;
    if (cnt == SLOW_DIV - 1)
      slow_osc_clk <= !slow_osc_clk;
  end
  // n pulses on one external clock, gap cycles per half
  task automatic pulse(input int idx, input int n, input int gap);
    repeat (n)
    begin
      repeat (gap) @(posedge mclk);
      ext_clock[idx] <= 1'b1;
      repeat (gap) @(posedge mclk);
      ext_clock[idx] <= 1'b0;
    end
  endtask
  // Static level on one external clock
  task automatic hold(input int idx, input bit v);
    ext_clock[idx] <= v;
  endtask
  // Line change after a wait; b picks line B
  task automatic set_line(input bit b, input int ch, input bit v,
                          input int gap);
    repeat (gap) @(posedge mclk);
    if (b)
      io_line_b[ch] <= v;
    else
      io_line_a[ch] <= v;
  endtask
endmodule

/* File: dv/tcc_monitor.sv */
// Checker of the timer block's APB port
`timescale 1ns/1ns
module tcc_monitor (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset, active low
  input tcc_pkg::tcc_apb_req_t apb_req, // Request
  input tcc_pkg::tcc_apb_rsp_t apb_rsp // Response
);
  import tcc_pkg::*;
  logic wr;
  logic rd;
  logic wp_q;
  logic [31:0] mode_q;
  logic [31:0] imr_q;
  logic en0_q;
  logic sure_q;
  // Access-edge write and setup-cycle read
  assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Shadow of protection bit, channel 0 mode and mask
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wp_q <= 1'b0;
      mode_q <= '0;
      imr_q <= '0;
      en0_q <= 1'b0;
      sure_q <= 1'b1;
    end
    else if (wr)
    begin
      if (apb_req.paddr == 8'hE4)
        wp_q <= apb_req.pwdata[0];
      if (apb_req.paddr == 8'h04 && !wp_q)
        mode_q <= apb_req.pwdata;
      if (apb_req.paddr == 8'h24)
        imr_q <= imr_q | (apb_req.pwdata & TCC_EVT_MASK);
      if (apb_req.paddr == 8'h28)
        imr_q <= imr_q & ~apb_req.pwdata;
      // B-load disable armed: clock state of channel 0 no longer known
      if (apb_req.paddr == 8'h04 && !wp_q && apb_req.pwdata[7])
        sure_q <= 1'b0;
      if (apb_req.paddr == 8'h00 && apb_req.pwdata[1:0] != 2'h0 &&
          !mode_q[7])
      begin
        en0_q <= !apb_req.pwdata[1]; // Off wins over on
        sure_q <= 1'b1;
      end
    end
  end
  // Read setup at one address, then its access phase
  sequence s_rd(logic [7:0] a);
    rd && apb_req.paddr == a;
  endsequence
  sequence s_acc;
    apb_req.psel && apb_req.penable;
  endsequence
  property p_rdy;
    apb_req.psel |-> apb_rsp.pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_unmap;
    rd && apb_req.paddr inside {8'h0C, 8'h4C, 8'h8C, 8'hD8}
      |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("hole");
  property p_map;
    s_rd(8'h84) |=> !apb_rsp.pslverr;
  endproperty
  a_map: assert property (p_map) else $error("slot 2");
  property p_wo;
    rd && apb_req.paddr inside {8'h00, 8'h40, 8'h24, 8'hC0}
      |=> apb_rsp.prdata == 32'h0;
  endproperty
  a_wo: assert property (p_wo) else $error("wo read");
  property p_mode;
    s_rd(8'h04) |=> apb_rsp.prdata == $past(mode_q);
  endproperty
  a_mode: assert property (p_mode) else $error("mode");
  property p_wpr;
    s_rd(8'hE4) |=> apb_rsp.prdata[0] == $past(wp_q);
  endproperty
  a_wpr: assert property (p_wpr) else $error("protect");
  property p_imr;
    s_rd(8'h2C) |=> apb_rsp.prdata == $past(imr_q);
  endproperty
  a_imr: assert property (p_imr) else $error("mask");
  property p_clk_on;
    s_rd(8'h20) ##0 sure_q |=> apb_rsp.prdata[16] == $past(en0_q);
  endproperty
  a_clk_on: assert property (p_clk_on) else $error("clock state");
  property p_cv;
    rd && apb_req.paddr[5:0] == 6'h10 && apb_req.paddr < 8'hC0
      |=> apb_rsp.prdata[31:16] == 16'h0;
  endproperty
  a_cv: assert property (p_cv) else $error("cv width");
  property p_hold;
    rd ##1 s_acc |=> $stable(apb_rsp.prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("prdata");
endmodule

/* File: dv/timer_channel_capture_control_tb_top.sv */
// Self-checking bench of the timer block
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module timer_channel_capture_control_tb_top;
  import tcc_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} tcc_exp_t;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  tcc_apb_req_t req = '0;
  tcc_apb_rsp_t rsp;
  logic slow_clk;
  logic [2:0] xclk;
  logic [2:0] la;
  logic [2:0] lb;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] lfsr = 16'h0009;
  tcc_exp_t expq[$];
  logic [7:0] offs[10] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18,
                           8'h1C, 8'h20, 8'h24, 8'h2C};
  logic [7:0] blk[6] = '{8'hC0, 8'hC4, 8'hC8, 8'hD0, 8'hD4, 8'hE4};
  always #10 mclk = ~mclk;
  tcc_top #(.NUM_CH(3), .CNT_W(16)) tcc_top_i (
    .mclk(mclk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .slow_osc_clk(slow_clk), .ext_clock(xclk),
    .io_line_a(la), .io_line_b(lb));
  tcc_io_model tcc_io_model_i (.mclk(mclk), .slow_osc_clk(slow_clk),
    .ext_clock(xclk), .io_line_a(la), .io_line_b(lb));
  // Pseudo-random words
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // One APB transfer; a read notes its expected answer
  task automatic apb(input bit w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m = '1,
                     input bit e = 1'b0);
    if (!w)
      expq.push_back('{d, m, e});
    req <= '{1'b1, 1'b0, w, a, w ? d : 32'h0};
    @(posedge mclk);
    req.penable <= 1'b1;
    do @(posedge mclk); while (rsp.pready !== 1'b1);
    req <= '0;
    @(posedge mclk);
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Compare each read answer with the oldest note
  always @(posedge mclk)
    if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
    begin
      tcc_exp_t x;
      x = expq.pop_front();
      `CHK("prdata", x.d & x.m, rsp.prdata & x.m)
      `CHK("pslverr", x.e, rsp.pslverr)
    end
  // Cycle ceiling against hangs
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  // Main sequence
  initial
  begin
    logic [31:0] v;
    int c;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (c = 0; c < 3; c++)
      foreach (offs[i]) apb(0, 8'(c * 64) + offs[i], '0);
    foreach (blk[i]) apb(0, blk[i], '0);
    apb(0, 8'h4C, '0, '1, 1'b1);
    apb(0, 8'hD8, '0, '1, 1'b1);
    $display("Test reset_map done");
    for (c = 0; c < 3; c++)
    begin
      v = {rnd(), rnd()};
      apb(1, 8'(c * 64 + 4), v);
      apb(0, 8'(c * 64 + 4), v);
      apb(1, 8'hE4, 32'h1);
      apb(1, 8'(c * 64 + 4), ~v);
      apb(1, 8'(c * 64 + 28), ~v);
      apb(0, 8'(c * 64 + 4), v);
      apb(0, 8'(c * 64 + 28), 32'h0);
      apb(1, 8'hE4, 32'h0);
    end
    apb(1, 8'h04, 32'h0);
    apb(1, 8'h14, 32'h1234);
    apb(0, 8'h14, 32'h0);
    apb(1, 8'h04, 32'h8000);
    apb(1, 8'h14, 32'h1234);
    apb(0, 8'h14, 32'h1234);
    apb(1, 8'h24, 32'hFFFFFFFF);
    apb(1, 8'h28, 32'h11);
    apb(1, 8'h24, 32'h0);
    apb(0, 8'h2C, 32'hE0);
    $display("Test registers done");
    apb(1, 8'h44, 32'h5);
    apb(1, 8'h40, 32'h5);
    tcc_io_model_i.pulse(0, 4, 2);
    repeat (3) @(posedge mclk);
    apb(0, 8'h50, 32'd4);
    apb(1, 8'h44, 32'hD);
    apb(1, 8'h40, 32'h4);
    apb(0, 8'h50, 32'd0);
    tcc_io_model_i.pulse(0, 3, 3);
    repeat (3) @(posedge mclk);
    apb(0, 8'h50, 32'd3);
    apb(1, 8'h40, 32'h2);
    tcc_io_model_i.pulse(0, 2, 1);
    apb(0, 8'h50, 32'd3);
    apb(0, 8'h60, 32'h0, 32'h10000);
    apb(1, 8'h40, 32'h3);
    tcc_io_model_i.pulse(0, 2, 1);
    apb(0, 8'h50, 32'd3);
    apb(1, 8'h40, 32'h1);
    apb(0, 8'h60, 32'h10000, 32'h10000);
    apb(1, 8'h44, 32'h16);
    tcc_io_model_i.pulse(1, 3, 2);
    apb(0, 8'h50, 32'd3);
    tcc_io_model_i.hold(0, 1'b1);
    tcc_io_model_i.pulse(1, 3, 2);
    tcc_io_model_i.hold(0, 1'b0);
    repeat (3) @(posedge mclk);
    apb(0, 8'h50, 32'd6);
    $display("Test clocking done");
    apb(1, 8'h84, 32'h00090045);
    apb(1, 8'h80, 32'h5);
    tcc_io_model_i.pulse(0, 3, 3);
    tcc_io_model_i.set_line(1'b0, 2, 1'b1, 3);
    tcc_io_model_i.pulse(0, 2, 3);
    tcc_io_model_i.set_line(1'b0, 2, 1'b0, 3);
    tcc_io_model_i.pulse(0, 2, 3);
    repeat (3) @(posedge mclk);
    apb(0, 8'h94, 32'd3);
    apb(0, 8'h98, 32'd5);
    apb(0, 8'h90, 32'd5);
    apb(0, 8'hA0, 32'h10060, 32'h10060);
    apb(1, 8'h84, 32'h000900C5);
    apb(1, 8'h80, 32'h4);
    tcc_io_model_i.pulse(0, 1, 3);
    tcc_io_model_i.set_line(1'b0, 2, 1'b1, 3);
    tcc_io_model_i.set_line(1'b0, 2, 1'b0, 3);
    repeat (3) @(posedge mclk);
    apb(0, 8'h98, 32'd1);
    apb(0, 8'hA0, 32'h0, 32'h10000);
    $display("Test capture done");
    apb(1, 8'h44, 32'h205);
    tcc_io_model_i.pulse(0, 2, 2);
    tcc_io_model_i.set_line(1'b1, 1, 1'b1, 2);
    repeat (3) @(posedge mclk);
    apb(0, 8'h50, 32'd8);
    tcc_io_model_i.set_line(1'b1, 1, 1'b0, 2);
    repeat (3) @(posedge mclk);
    apb(0, 8'h50, 32'd0);
    apb(1, 8'h44, 32'h705);
    tcc_io_model_i.pulse(0, 2, 2);
    tcc_io_model_i.set_line(1'b0, 1, 1'b1, 2);
    repeat (3) @(posedge mclk);
    apb(0, 8'h50, 32'd0);
    $display("Test trigger done");
    apb(1, 8'h1C, 32'h5);
    apb(1, 8'h04, 32'h4000);
    apb(1, 8'h00, 32'h1);
    apb(1, 8'hC0, 32'h1);
    repeat (40) @(posedge mclk);
    apb(0, 8'h10, 32'h0, 32'hFFF8);
    apb(0, 8'h20, 32'h10010, 32'h10010);
    $display("Test compare done");
    close_out();
  end
endmodule
bind tcc_top tcc_monitor tcc_monitor_i (
  .mclk(mclk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp));

/* File: inc/tcc_pkg.sv */
// Shared constants and types of the three-channel timer block
package tcc_pkg;
  // Channel count, counter width and address layout
  localparam int TCC_NUM_CH = 3;
  localparam int TCC_CNT_W = 16;
  localparam int TCC_MAX_CH = 3;
  localparam logic [7:0] TCC_CH_STRIDE = 8'h40;
  localparam logic [7:0] TCC_BLK_BASE = 8'hC0;
  // Per-channel register offsets inside one stride
  localparam logic [5:0] TCC_OFF_CMD = 6'h00;
  localparam logic [5:0] TCC_OFF_MODE = 6'h04;
  localparam logic [5:0] TCC_OFF_STEP = 6'h08;
  localparam logic [5:0] TCC_OFF_CV = 6'h10;
  localparam logic [5:0] TCC_OFF_RA = 6'h14;
  localparam logic [5:0] TCC_OFF_RB = 6'h18;
  localparam logic [5:0] TCC_OFF_RC = 6'h1C;
  localparam logic [5:0] TCC_OFF_SR = 6'h20;
  localparam logic [5:0] TCC_OFF_IER = 6'h24;
  localparam logic [5:0] TCC_OFF_IDR = 6'h28;
  localparam logic [5:0] TCC_OFF_IMR = 6'h2C;
  // Block-level register offsets
  localparam logic [7:0] TCC_OFF_BCR = 8'hC0;
  localparam logic [7:0] TCC_OFF_BMR = 8'hC4;
  localparam logic [7:0] TCC_OFF_QIER = 8'hC8;
  localparam logic [7:0] TCC_OFF_QIDR = 8'hCC;
  localparam logic [7:0] TCC_OFF_QIMR = 8'hD0;
  localparam logic [7:0] TCC_OFF_QISR = 8'hD4;
  localparam logic [7:0] TCC_OFF_WPMR = 8'hE4;
  // Command, protection and status bit positions
  localparam int TCC_CMD_ON = 0;
  localparam int TCC_CMD_OFF = 1;
  localparam int TCC_CMD_TRG = 2;
  localparam int TCC_BCR_SYNC = 0;
  localparam int TCC_WP_BIT = 0;
  localparam int TCC_SR_COV = 0;
  localparam int TCC_SR_CPC = 4;
  localparam int TCC_SR_LDA = 5;
  localparam int TCC_SR_LDB = 6;
  localparam int TCC_SR_ETRG = 7;
  localparam int TCC_SR_CLKSTA = 16;
  localparam logic [31:0] TCC_EVT_MASK = 32'h000000F1;
  localparam logic [31:0] TCC_QIRQ_MASK = 32'h00000007;
  localparam logic [31:0] TCC_REG_RST = 32'h00000000;
  // Prescaler taps for the divide-by-2, 8, 32 and 128 clocks
  localparam int TCC_PRE_W = 7;
  localparam int TCC_TAP_DIV2 = 0;
  localparam int TCC_TAP_DIV8 = 2;
  localparam int TCC_TAP_DIV32 = 4;
  localparam int TCC_TAP_DIV128 = 6;
  // Edge selection codes
  localparam logic [1:0] TCC_EDGE_NONE = 2'h0;
  localparam logic [1:0] TCC_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCC_EDGE_FALL = 2'h2;
  localparam logic [1:0] TCC_EDGE_BOTH = 2'h3;
  // Channel mode word, capture view
  typedef struct packed {
    logic [11:0] resv_hi;
    logic [1:0] load_b_edge_select;
    logic [1:0] load_a_edge_select;
    logic wave_mode;
    logic compare_c_trigger_en;
    logic [2:0] resv_mid;
    logic trigger_line_select;
    logic [1:0] trigger_edge_select;
    logic disable_on_b_load;
    logic stop_on_b_load;
    logic [1:0] burst_select;
    logic clock_invert;
    logic [2:0] clock_source_select;
  } tcc_cmr_t;
  // APB request and response bundles
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tcc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tcc_apb_rsp_t;
endpackage

/* File: rtl/tcc_edge.sv */
// Rising and falling edge detector for a group of levels
`timescale 1ns/1ns
module tcc_edge #(
  parameter int W = 3
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [W-1:0] lvl, // Levels to watch
  output logic [W-1:0] rise, // Pulse on a 0 to 1 change
  output logic [W-1:0] fall // Pulse on a 1 to 0 change
);
  logic [W-1:0] prev_q;

  // Previous sample of each level
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      prev_q <= '0;
    else
      prev_q <= lvl;
  end

  assign rise = lvl & ~prev_q;
  assign fall = ~lvl & prev_q;
endmodule

/* File: rtl/tcc_prescaler.sv */
// Free-running divider giving the master clock divided levels
`timescale 1ns/1ns
module tcc_prescaler (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  output logic [3:0] div_lvl // Divided levels: /2, /8, /32, /128
);
  import tcc_pkg::*;
  logic [TCC_PRE_W-1:0] cnt_q;

  // Ripple-free binary counter
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  // Each tap is a square wave at its own rate
  assign div_lvl = {cnt_q[TCC_TAP_DIV128], cnt_q[TCC_TAP_DIV32],
                    cnt_q[TCC_TAP_DIV8], cnt_q[TCC_TAP_DIV2]};
endmodule

/* File: rtl/tcc_top.sv */
// Timer block: APB registers and capture-mode control of the channels
`timescale 1ns/1ns
module tcc_top #(
  parameter int NUM_CH = tcc_pkg::TCC_NUM_CH,
  parameter int CNT_W = tcc_pkg::TCC_CNT_W
) (
  input wire logic mclk, // System clock, 50 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input tcc_pkg::tcc_apb_req_t apb_req, // APB request from the master
  output tcc_pkg::tcc_apb_rsp_t apb_rsp, // APB response to the master
  input wire logic slow_osc_clk, // Slow clock level
  input wire logic [2:0] ext_clock, // External clock levels 0 to 2
  input wire logic [NUM_CH-1:0] io_line_a, // Line A of each channel
  input wire logic [NUM_CH-1:0] io_line_b // Line B of each channel
);
  import tcc_pkg::*;

  // Refuse shapes the address map and read path cannot serve
  if (NUM_CH < 1 || NUM_CH > TCC_MAX_CH || CNT_W < 2 || CNT_W > 32)
  begin : g_bad_param
    $error("tcc_top: unsupported channel count or counter width");
  end

  // Edge match for a two-bit edge selection code
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic r,
                                    input logic f);
    edge_hit = ((sel == TCC_EDGE_RISE) & r) |
               ((sel == TCC_EDGE_FALL) & f) |
               ((sel == TCC_EDGE_BOTH) & (r | f));
  endfunction

  logic setup;
  logic wr_acc;
  logic rd_acc;
  logic blk_hit;
  logic [1:0] ch_sel;
  logic [5:0] reg_off;
  logic [31:0] wdata;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [31:0] rd_d;
  logic err_d;
  logic [31:0] rd_ch [NUM_CH];
  logic [NUM_CH-1:0] ok_ch;
  logic [3:0] div_lvl;
  logic wp_q;
  logic [31:0] bmr_q;
  logic [31:0] qmask_q;
  logic sync_trg;

  // APB phase decode; the slave never inserts wait states
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
  assign blk_hit = apb_req.paddr >= TCC_BLK_BASE;
  assign ch_sel = apb_req.paddr[7:6];
  assign reg_off = apb_req.paddr[5:0];
  assign wdata = apb_req.pwdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.prdata = prdata_q;
  assign apb_rsp.pslverr = pslverr_q;

  // Shared prescaler for the divided master clock
  tcc_prescaler u_pre (
    .mclk(mclk),
    .rst_n(rst_n),
    .div_lvl(div_lvl)
  );

  // Block-level write protection and mode registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wp_q <= 1'b0;
      bmr_q <= TCC_REG_RST;
    end
    else if (wr_acc)
    begin
      if (apb_req.paddr == TCC_OFF_WPMR)
        wp_q <= wdata[TCC_WP_BIT];
      if (apb_req.paddr == TCC_OFF_BMR && !wp_q)
        bmr_q <= wdata;
    end
  end

  // Decoder interrupt mask, set and clear by separate registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      qmask_q <= TCC_REG_RST;
    else if (wr_acc && apb_req.paddr == TCC_OFF_QIER)
      qmask_q <= qmask_q | (wdata & TCC_QIRQ_MASK);
    else if (wr_acc && apb_req.paddr == TCC_OFF_QIDR)
      qmask_q <= qmask_q & ~wdata;
  end

  // Block command: one write triggers every channel at once
  assign sync_trg = wr_acc && apb_req.paddr == TCC_OFF_BCR &&
                    wdata[TCC_BCR_SYNC];

  // Read data and error for the addressed register
  always_comb
  begin
    rd_d = '0;
    err_d = 1'b0;
    if (blk_hit)
    begin
      unique case (apb_req.paddr)
        TCC_OFF_BCR, TCC_OFF_QIER, TCC_OFF_QIDR, TCC_OFF_QISR:
          rd_d = '0;
        TCC_OFF_BMR:
          rd_d = bmr_q;
        TCC_OFF_QIMR:
          rd_d = qmask_q;
        TCC_OFF_WPMR:
          rd_d = {31'h0, wp_q};
        default:
          err_d = 1'b1;
      endcase
    end
    else if (int'(ch_sel) < NUM_CH)
    begin
      rd_d = rd_ch[ch_sel];
      err_d = ~ok_ch[ch_sel];
    end
    else
      err_d = 1'b1;
  end

  // Read data captured in the setup phase, held through the access
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= apb_req.pwrite ? 32'h0 : rd_d;
      pslverr_q <= err_d;
    end
  end

  // One register set and counter per channel
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    tcc_cmr_t cmr;
    logic [31:0] mode_q;
    logic [1:0] step_q;
    logic [CNT_W-1:0] cv_q;
    logic [CNT_W-1:0] ra_q;
    logic [CNT_W-1:0] rb_q;
    logic [CNT_W-1:0] rc_q;
    logic [31:0] sr_q;
    logic [31:0] mask_q;
    logic en_q;
    logic stop_q;
    logic hit;
    logic wr_cmd;
    logic src_lvl;
    logic gate_lvl;
    logic cnt_lvl;
    logic [2:0] rise;
    logic [2:0] fall;
    logic tick;
    logic running;
    logic capture;
    logic ld_a;
    logic ld_b;
    logic trg_r;
    logic trg_f;
    logic etrg;
    logic cpc;
    logic trig;
    logic [31:0] evt;
    logic [31:0] rd_clr;
    logic [31:0] rd_v;
    logic ok_v;

    assign cmr = mode_q;
    assign hit = ~blk_hit & (ch_sel == 2'(i));
    assign wr_cmd = wr_acc & hit & (reg_off == TCC_OFF_CMD);
    assign capture = ~cmr.wave_mode;
    assign running = en_q & ~stop_q;

    // Counter clock source selection
    always_comb
    begin
      unique case (cmr.clock_source_select)
        3'h0: src_lvl = div_lvl[0];
        3'h1: src_lvl = div_lvl[1];
        3'h2: src_lvl = div_lvl[2];
        3'h3: src_lvl = div_lvl[3];
        3'h4: src_lvl = slow_osc_clk;
        3'h5: src_lvl = ext_clock[0];
        3'h6: src_lvl = ext_clock[1];
        3'h7: src_lvl = ext_clock[2];
      endcase
    end

    // Burst gating with one of the external clocks
    always_comb
    begin
      unique case (cmr.burst_select)
        2'h0: gate_lvl = src_lvl;
        2'h1: gate_lvl = src_lvl & ext_clock[0];
        2'h2: gate_lvl = src_lvl & ext_clock[1];
        2'h3: gate_lvl = src_lvl & ext_clock[2];
      endcase
    end

    // Inverting turns the falling edge into the counted one
    assign cnt_lvl = gate_lvl ^ cmr.clock_invert;

    // Edges of the counter clock and both lines
    tcc_edge #(
      .W(3)
    ) u_edge (
      .mclk(mclk),
      .rst_n(rst_n),
      .lvl({cnt_lvl, io_line_a[i], io_line_b[i]}),
      .rise(rise),
      .fall(fall)
    );

    assign tick = rise[2] & running;
    // Load edges always come from line A
    assign ld_a = capture & edge_hit(cmr.load_a_edge_select,
                                     rise[1], fall[1]);
    assign ld_b = capture & edge_hit(cmr.load_b_edge_select,
                                     rise[1], fall[1]);
    // Trigger input picked by the line select bit
    assign trg_r = cmr.trigger_line_select ? rise[1] : rise[0];
    assign trg_f = cmr.trigger_line_select ? fall[1] : fall[0];
    assign etrg = capture & edge_hit(cmr.trigger_edge_select,
                                     trg_r, trg_f);
    assign cpc = tick & (cv_q == rc_q);
    // Any trigger clears the counter and restarts its clock if enabled
    assign trig = (wr_cmd & wdata[TCC_CMD_TRG]) | sync_trg | etrg |
                  (capture & cmr.compare_c_trigger_en & cpc);

    // Clock enable: off beats on in one write, zeros are ignored
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        en_q <= 1'b0;
      else if (wr_cmd && wdata[TCC_CMD_OFF])
        en_q <= 1'b0;
      else if (ld_b && cmr.disable_on_b_load)
        en_q <= 1'b0;
      else if (wr_cmd && wdata[TCC_CMD_ON])
        en_q <= 1'b1;
    end

    // Stopped clock waits for the next trigger
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        stop_q <= 1'b1;
      else if (trig)
        stop_q <= 1'b0;
      else if (ld_b && cmr.stop_on_b_load)
        stop_q <= 1'b1;
    end

    // Counter value
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        cv_q <= '0;
      else if (trig)
        cv_q <= '0;
      else if (tick)
        cv_q <= cv_q + 1'b1;
    end

    // Mode and stepper registers under write protection
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
      begin
        mode_q <= TCC_REG_RST;
        step_q <= '0;
      end
      else if (wr_acc && hit && !wp_q)
      begin
        if (reg_off == TCC_OFF_MODE)
          mode_q <= wdata;
        if (reg_off == TCC_OFF_STEP)
          step_q <= wdata[1:0];
      end
    end

    // Register A: counter capture, or software in waveform mode
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        ra_q <= '0;
      else if (ld_a)
        ra_q <= cv_q;
      else if (wr_acc && hit && reg_off == TCC_OFF_RA && !wp_q &&
               cmr.wave_mode)
        ra_q <= wdata[CNT_W-1:0];
    end

    // Register B: counter capture, or software in waveform mode
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        rb_q <= '0;
      else if (ld_b)
        rb_q <= cv_q;
      else if (wr_acc && hit && reg_off == TCC_OFF_RB && !wp_q &&
               cmr.wave_mode)
        rb_q <= wdata[CNT_W-1:0];
    end

    // Compare register C
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        rc_q <= '0;
      else if (wr_acc && hit && reg_off == TCC_OFF_RC && !wp_q)
        rc_q <= wdata[CNT_W-1:0];
    end

    // Sticky events; a read clears only the bits it returned
    assign evt = {24'h0, etrg, ld_b, ld_a, cpc, 3'h0,
                  tick & (&cv_q)} & TCC_EVT_MASK;
    assign rd_clr = (rd_acc && hit && reg_off == TCC_OFF_SR) ?
                    (prdata_q & TCC_EVT_MASK) : 32'h0;

    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        sr_q <= TCC_REG_RST;
      else
        sr_q <= (sr_q & ~rd_clr) | evt;
    end

    // Event mask, set and clear by separate registers
    always_ff @(posedge mclk)
    begin
      if (!rst_n)
        mask_q <= TCC_REG_RST;
      else if (wr_acc && hit && reg_off == TCC_OFF_IER)
        mask_q <= mask_q | (wdata & TCC_EVT_MASK);
      else if (wr_acc && hit && reg_off == TCC_OFF_IDR)
        mask_q <= mask_q & ~wdata;
    end

    // Channel read data and address validity
    always_comb
    begin
      rd_v = '0;
      ok_v = 1'b1;
      unique case (reg_off)
        TCC_OFF_CMD, TCC_OFF_IER, TCC_OFF_IDR:
          rd_v = '0;
        TCC_OFF_MODE:
          rd_v = mode_q;
        TCC_OFF_STEP:
          rd_v = {30'h0, step_q};
        TCC_OFF_CV:
          rd_v = 32'(cv_q);
        TCC_OFF_RA:
          rd_v = 32'(ra_q);
        TCC_OFF_RB:
          rd_v = 32'(rb_q);
        TCC_OFF_RC:
          rd_v = 32'(rc_q);
        TCC_OFF_SR:
          rd_v = sr_q | (32'(en_q) << TCC_SR_CLKSTA);
        TCC_OFF_IMR:
          rd_v = mask_q;
        default:
          ok_v = 1'b0;
      endcase
    end

    assign rd_ch[i] = rd_v;
    assign ok_ch[i] = ok_v;
  end
endmodule
